// [inc/torque_limit_regs.vh]
// Register offsets, field positions, reset values and percent maximum of the torque limiter
`ifndef TORQUE_LIMIT_REGS_VH
`define TORQUE_LIMIT_REGS_VH
`define TL_FWD_INT_OFS 12'h000
`define TL_REV_INT_OFS 12'h004
`define TL_FWD_EXT_OFS 12'h008
`define TL_REV_EXT_OFS 12'h00C
`define TL_MAX_TRQ_OFS 12'h010
`define TL_SLOT_SEL_OFS 12'h014
`define TL_TRQ_REF_OFS 12'h018
`define TL_OTHER_OFS 12'h01C
`define TL_IN_MON_OFS 12'h020
`define TL_OUT_MON_OFS 12'h024
`define TL_IRQ_STAT_OFS 12'h028
`define TL_IRQ_MASK_OFS 12'h02C
`define TL_EFF_LIM_OFS 12'h030
`define TL_PCT_MAX 10'd800
`define TL_INT_RST 10'd800
`define TL_EXT_RST 10'd100
`define TL_MAXTRQ_RST 10'd800
`define TL_MON_FWD_BIT 6
`define TL_MON_REV_BIT 7
`define TL_IRQ_ON_BIT 0
`define TL_IRQ_OFF_BIT 1
`endif

// [rtl/limit_select.v]
// Effective limit for one direction: internal, optional external, capped by motor maximum
`default_nettype none
`include "torque_limit_regs.vh"
module limit_select
(
	input wire pclk,
	input wire presetn,
	input wire [9:0] internal_pct,
	input wire [9:0] external_pct,
	input wire external_on,
	input wire [9:0] motor_max_pct,
	output reg [9:0] limit_r
);
	reg [9:0] pick;
	always @*
	begin
		pick = internal_pct;
		if (external_on && external_pct < pick)
			pick = external_pct;
		if (pick > motor_max_pct)
			pick = motor_max_pct;
	end
	always @(posedge pclk or negedge presetn)
	begin
		// Same as the reset state of the internal limit registers, so no false clamp after reset
		if (!presetn)
			limit_r <= `TL_INT_RST;
		else
			limit_r <= pick;
	end
endmodule
`default_nettype wire

// [rtl/torque_limit_control.v]
// Torque limiter with external limit contacts, clamp flag routing and APB registers
//
// Functional notes
// - Forward and reverse internal limits, 0 to 800 percent, reset to 800.
// - All limits are percent of rated torque against the torque reference.
// - A limit above motor maximum torque is replaced by the maximum.
// - Limit-active output low while reference exceeds limit, high below.
// - Selector 0 routes flag nowhere; 1, 2, 3 to slots one to three.
// - Each output slot is the OR of all signals assigned to it.
// - Forward external limit applies while its active-low input is low.
// - Reverse external limit applies while its active-low input is low.
// - External limits 0 to 800 percent, reset to 100, used only when contact active.
// - Contact input states shown at monitor bits 6 and 7.
`default_nettype none
`include "torque_limit_regs.vh"
module torque_limit_control
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [10:0] torque_ref,
	input wire fwd_ext_limit_in_n,
	input wire rev_ext_limit_in_n,
	output reg torque_limit_active_out_n,
	output reg output_slot_one_n,
	output reg output_slot_two_n,
	output reg output_slot_three_n,
	output reg irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [9:0] fwd_internal_limit_r;
	reg [9:0] rev_internal_limit_r;
	reg [9:0] fwd_external_limit_r;
	reg [9:0] rev_external_limit_r;
	reg [9:0] motor_max_r;
	reg [1:0] limit_flag_slot_select_r;
	reg [2:0] other_slots_r;
	reg [1:0] irq_stat_r;
	reg [1:0] irq_mask_r;
	reg [1:0] fwd_sync_r;
	reg [1:0] rev_sync_r;
	reg clamp_r;
	wire [9:0] fwd_lim;
	wire [9:0] rev_lim;

	// Clamp writes to the legal percent range
	function [9:0] pct_clip;
		input [31:0] d;
		begin
			if (d[31:10] != 22'd0 || d[9:0] > `TL_PCT_MAX)
				pct_clip = `TL_PCT_MAX;
			else
				pct_clip = d[9:0];
		end
	endfunction

	function is_reg;
		input [11:0] a;
		begin
			is_reg = (a[1:0] == 2'b00) && (a <= `TL_EFF_LIM_OFS);
		end
	endfunction

	// Strict compare: a reference equal to the limit is not clamped
	function over_limit;
		input [10:0] mag;
		input [9:0] lim;
		begin
			over_limit = mag > {1'b0, lim};
		end
	endfunction

	// One-hot slot of the clamp flag; code 0 leaves every slot alone
	function [2:0] slot_onehot;
		input [1:0] sel;
		begin
			case (sel)
				2'd1: slot_onehot = 3'b001;
				2'd2: slot_onehot = 3'b010;
				2'd3: slot_onehot = 3'b100;
				default: slot_onehot = 3'b000;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Contact inputs
	// ----------------------------------------
	// Two stages against metastability; logic reads only the second
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fwd_sync_r <= 2'b11;
			rev_sync_r <= 2'b11;
		end
		else
		begin
			fwd_sync_r <= {fwd_sync_r[0], fwd_ext_limit_in_n};
			rev_sync_r <= {rev_sync_r[0], rev_ext_limit_in_n};
		end
	end
	wire fwd_ext_on = ~fwd_sync_r[1];
	wire rev_ext_on = ~rev_sync_r[1];

	// ----------------------------------------
	// Limit selection
	// ----------------------------------------
	limit_select u_fwd
	(
		.pclk(pclk),
		.presetn(presetn),
		.internal_pct(fwd_internal_limit_r),
		.external_pct(fwd_external_limit_r),
		.external_on(fwd_ext_on),
		.motor_max_pct(motor_max_r),
		.limit_r(fwd_lim)
	);
	limit_select u_rev
	(
		.pclk(pclk),
		.presetn(presetn),
		.internal_pct(rev_internal_limit_r),
		.external_pct(rev_external_limit_r),
		.external_on(rev_ext_on),
		.motor_max_pct(motor_max_r),
		.limit_r(rev_lim)
	);

	// ----------------------------------------
	// Clamp detection and slot routing
	// ----------------------------------------
	// Signed reference in percent; negative values are reverse torque
	wire ref_neg = torque_ref[10];
	wire [10:0] ref_mag = ref_neg ? (~torque_ref + 11'd1) : torque_ref;
	wire fwd_over = over_limit(ref_mag, fwd_lim);
	wire rev_over = over_limit(ref_mag, rev_lim);
	wire clamp_nxt = ref_neg ? rev_over : fwd_over;
	wire [2:0] sel_onehot = slot_onehot(limit_flag_slot_select_r);
	wire [2:0] flag_route;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_route
			assign flag_route[g] = clamp_r && sel_onehot[g];
		end
	endgenerate
	wire [2:0] slot_nxt = flag_route | other_slots_r;

	// ----------------------------------------
	// Outputs and events
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clamp_r <= 1'b0;
			torque_limit_active_out_n <= 1'b1;
			output_slot_one_n <= 1'b1;
			output_slot_two_n <= 1'b1;
			output_slot_three_n <= 1'b1;
		end
		else
		begin
			clamp_r <= clamp_nxt;
			torque_limit_active_out_n <= ~clamp_r;
			output_slot_one_n <= ~slot_nxt[0];
			output_slot_two_n <= ~slot_nxt[1];
			output_slot_three_n <= ~slot_nxt[2];
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite && is_reg(paddr);
	wire rd_stat = acc && !pwrite && (paddr == `TL_IRQ_STAT_OFS);
	wire clamp_start = ~clamp_r & clamp_nxt;
	wire clamp_end = clamp_r & ~clamp_nxt;
	reg [1:0] ev;
	always @*
	begin
		ev = 2'b00;
		ev[`TL_IRQ_ON_BIT] = clamp_start;
		ev[`TL_IRQ_OFF_BIT] = clamp_end;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fwd_internal_limit_r <= `TL_INT_RST;
			rev_internal_limit_r <= `TL_INT_RST;
			fwd_external_limit_r <= `TL_EXT_RST;
			rev_external_limit_r <= `TL_EXT_RST;
			motor_max_r <= `TL_MAXTRQ_RST;
			limit_flag_slot_select_r <= 2'd0;
			other_slots_r <= 3'd0;
			irq_mask_r <= 2'd0;
		end
		else
		begin
			if (wr)
			begin
				case (paddr)
					`TL_FWD_INT_OFS: fwd_internal_limit_r <= pct_clip(pwdata);
					`TL_REV_INT_OFS: rev_internal_limit_r <= pct_clip(pwdata);
					`TL_FWD_EXT_OFS: fwd_external_limit_r <= pct_clip(pwdata);
					`TL_REV_EXT_OFS: rev_external_limit_r <= pct_clip(pwdata);
					`TL_MAX_TRQ_OFS: motor_max_r <= pct_clip(pwdata);
					`TL_SLOT_SEL_OFS: limit_flag_slot_select_r <= pwdata[1:0];
					`TL_OTHER_OFS: other_slots_r <= pwdata[2:0];
					`TL_IRQ_MASK_OFS: irq_mask_r <= pwdata[1:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Read clear drops only the bits the read returned, so an event
	// in the capture cycle survives; new events win over the clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_r <= 2'b00;
		else if (rd_stat)
			irq_stat_r <= (irq_stat_r & ~prdata[1:0]) | ev;
		else
			irq_stat_r <= irq_stat_r | ev;
	end

	// Level output, one cycle behind the status bits
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_r & irq_mask_r);
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	reg [31:0] rdata_nxt;
	always @*
	begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`TL_FWD_INT_OFS: rdata_nxt = {22'd0, fwd_internal_limit_r};
			`TL_REV_INT_OFS: rdata_nxt = {22'd0, rev_internal_limit_r};
			`TL_FWD_EXT_OFS: rdata_nxt = {22'd0, fwd_external_limit_r};
			`TL_REV_EXT_OFS: rdata_nxt = {22'd0, rev_external_limit_r};
			`TL_MAX_TRQ_OFS: rdata_nxt = {22'd0, motor_max_r};
			`TL_SLOT_SEL_OFS: rdata_nxt = {30'd0, limit_flag_slot_select_r};
			`TL_OTHER_OFS: rdata_nxt = {29'd0, other_slots_r};
			`TL_IN_MON_OFS:
			begin
				rdata_nxt[`TL_MON_FWD_BIT] = fwd_ext_on;
				rdata_nxt[`TL_MON_REV_BIT] = rev_ext_on;
			end
			`TL_OUT_MON_OFS: rdata_nxt = {28'd0, clamp_r, slot_nxt};
			`TL_IRQ_STAT_OFS: rdata_nxt = {30'd0, irq_stat_r};
			`TL_IRQ_MASK_OFS: rdata_nxt = {30'd0, irq_mask_r};
			`TL_EFF_LIM_OFS: rdata_nxt = {6'd0, rev_lim, 6'd0, fwd_lim};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// APB response
	// ----------------------------------------
	// One wait state: pready rises in the first access cycle's next edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !is_reg(paddr);
			prdata <= (psel && penable && !pready && !pwrite) ? rdata_nxt : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// [verification/torque_limit_control_asserts.sv]
// Port assertions for the torque limiter
`default_nettype none
module torque_limit_checks (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [10:0] torque_ref,
	input wire logic fwd_ext_limit_in_n,
	input wire logic rev_ext_limit_in_n,
	input wire logic torque_limit_active_out_n,
	input wire logic output_slot_one_n,
	input wire logic output_slot_two_n,
	input wire logic output_slot_three_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_wait;
		psel && penable && !pready;
	endsequence
	// Eight quiet edges cover sync, limit, clamp and output stages
	sequence quiet_in;
		($stable(torque_ref) && $stable({fwd_ext_limit_in_n, rev_ext_limit_in_n}) && !(psel && pwrite))[*8];
	endsequence
	ready_one_wait_a: assert property (access_wait |=> pready) else $error("late ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	err_data_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000) else $error("error data");
	idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle data");
	zero_ref_free_a: assert property ((torque_ref == 11'h000)[*4] |=> torque_limit_active_out_n)
		else $error("clamp at zero");
	clamp_steady_a: assert property (quiet_in |-> $stable(torque_limit_active_out_n))
		else $error("clamp moved");
	slots_steady_a: assert property (quiet_in |-> $stable({output_slot_one_n, output_slot_two_n, output_slot_three_n}))
		else $error("slot moved");
endmodule
bind torque_limit_control torque_limit_checks chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .torque_ref, .fwd_ext_limit_in_n, .rev_ext_limit_in_n, .torque_limit_active_out_n,
	.output_slot_one_n, .output_slot_two_n, .output_slot_three_n);
`default_nettype wire

// [verification/host_contacts.sv]
// Host model driving the two external limit contacts
`default_nettype none
module host_contacts (
	input wire logic pclk,
	input wire logic fwd_on,
	input wire logic rev_on,
	output var logic fwd_ext_limit_in_n = 1'b1,
	output var logic rev_ext_limit_in_n = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts are active low, closed while the host asks for a limit
	always @(posedge pclk)
	begin
		fwd_ext_limit_in_n <= !fwd_on;
		rev_ext_limit_in_n <= !rev_on;
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the torque limiter
`default_nettype none
`include "torque_limit_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fwd_on = 0, rev_on = 0, fo, ro, rerr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rdat, prdata;
	logic [10:0] torque_ref = 11'h000;
	logic [9:0] lim [4];
	logic [9:0] mmax, rst_v [6];
	logic [1:0] sel;
	logic [2:0] oth;
	logic pready, pslverr, fwd_n, rev_n, out_n, s1, s2, s3, irq;
	int n_errors = 0, num_checks = 0, cyc = 0;
	always #4 pclk = ~pclk;
	host_contacts host_u (.pclk, .fwd_on, .rev_on, .fwd_ext_limit_in_n(fwd_n), .rev_ext_limit_in_n(rev_n));
	torque_limit_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .torque_ref, .fwd_ext_limit_in_n(fwd_n), .rev_ext_limit_in_n(rev_n),
		.torque_limit_active_out_n(out_n), .output_slot_one_n(s1), .output_slot_two_n(s2),
		.output_slot_three_n(s3), .irq);
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_errors++;
			test_done();
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [9:0] eff(input logic [9:0] i, e, input logic on);
		logic [9:0] l;
		l = (on && e < i) ? e : i;
		return (l > mmax) ? mmax : l;
	endfunction
	function automatic logic clamp_n();
		int t;
		t = $signed(torque_ref);
		return (t < 0) ? !(-t > eff(lim[1], lim[3], rev_on)) : !(t > eff(lim[0], lim[2], fwd_on));
	endfunction
	function automatic logic [2:0] slots_n(input logic cl_n);
		return ~(oth | ((cl_n || sel == 2'd0) ? 3'b000 : 3'b001 << (sel - 2'd1)));
	endfunction
	initial
	begin
		void'($urandom(32'h0000_09d5));
		rst_v = '{`TL_INT_RST, `TL_INT_RST, `TL_EXT_RST, `TL_EXT_RST, `TL_MAXTRQ_RST, 10'h000};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			apb(0, 12'(4 * k), 32'h0000_0000);
			`CHK(rdat, {22'h0, rst_v[k]})
		end
		apb(1, 12'h040, 32'h0000_0001);
		`CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
		apb(1, `TL_FWD_INT_OFS, 32'h0000_0384);
		apb(0, `TL_FWD_INT_OFS, 32'h0000_0000);
		`CHK(rdat, {22'h0, `TL_PCT_MAX})
		for (int n = 0; n < 40; n++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				lim[k] = (n < 2) ? 10'(800 * n) : 10'($urandom_range(800));
				apb(1, 12'(4 * k), {22'h0, lim[k]});
			end
			mmax = (n < 2) ? 10'd800 : 10'($urandom_range(800));
			sel = 2'($urandom_range(3));
			oth = 3'($urandom_range(7));
			apb(1, `TL_MAX_TRQ_OFS, {22'h0, mmax});
			apb(1, `TL_SLOT_SEL_OFS, {30'h0, sel});
			apb(1, `TL_OTHER_OFS, {29'h0, oth});
			fo = 1'($urandom_range(1));
			ro = 1'($urandom_range(1));
			fwd_on <= fo;
			rev_on <= ro;
			// Two passes in three sit exactly on a limit, which must not clamp
			torque_ref <= (n % 3 == 0) ? {1'b0, eff(lim[0], lim[2], fo)} :
				(n % 3 == 1) ? -{1'b0, eff(lim[1], lim[3], ro)} : 11'($urandom);
			repeat (12) @(posedge pclk);
			`CHK(out_n, clamp_n())
			`CHK({s3, s2, s1}, slots_n(clamp_n()))
			apb(0, `TL_EFF_LIM_OFS, 32'h0000_0000);
			`CHK(rdat, {6'h0, eff(lim[1], lim[3], ro), 6'h0, eff(lim[0], lim[2], fo)})
			apb(0, `TL_IN_MON_OFS, 32'h0000_0000);
			`CHK(rdat[7:6], {ro, fo})
			apb(0, `TL_OUT_MON_OFS, 32'h0000_0000);
			`CHK(rdat[3:0], {!clamp_n(), ~slots_n(clamp_n())})
		end
		apb(1, `TL_IRQ_MASK_OFS, 32'h0000_0001);
		apb(1, `TL_FWD_INT_OFS, 32'h0000_0032);
		apb(1, `TL_MAX_TRQ_OFS, 32'h0000_0320);
		fwd_on <= 1'b0;
		torque_ref <= 11'h000;
		repeat (12) @(posedge pclk);
		apb(0, `TL_IRQ_STAT_OFS, 32'h0000_0000);
		torque_ref <= 11'h064;
		repeat (12) @(posedge pclk);
		`CHK({irq, out_n}, 2'b10)
		apb(0, `TL_IRQ_STAT_OFS, 32'h0000_0000);
		`CHK(rdat[0], 1'b1)
		torque_ref <= 11'h000;
		repeat (12) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1, `TL_IRQ_MASK_OFS, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		apb(0, `TL_IRQ_STAT_OFS, 32'h0000_0000);
		`CHK(rdat[1:0], 2'b10)
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		test_done();
	end
endmodule
`default_nettype wire
